// [qsrc_pkg.sv]
// Shared constants and types of the quad serial read controller
package qsrc_pkg;
   // ****************************************
   // Field encodings
   // ****************************************
   localparam logic [1:0] QSRC_LINES_1 = 2'h0;
   localparam logic [1:0] QSRC_LINES_2 = 2'h1;
   localparam logic [1:0] QSRC_LINES_4 = 2'h2;
   localparam logic [1:0] QSRC_PINS_3 = 2'h0;
   localparam logic [1:0] QSRC_PINS_4 = 2'h1;
   localparam logic [1:0] QSRC_PINS_6 = 2'h2;
   // ****************************************
   // Widths and reset values
   // ****************************************
   localparam int QSRC_CMD_W = 8;
   localparam int QSRC_ADDR_W = 24;
   localparam int QSRC_HDR_W = 32;
   localparam logic [7:0] QSRC_HDR_LAST = 8'h1f;
   localparam logic [7:0] QSRC_DIV_RST = 8'h00;
   localparam logic [7:0] QSRC_DIV_MIN = 8'h02;
   localparam logic [3:0] QSRC_OE_RST = 4'h0;
   localparam logic [3:0] QSRC_OE_D0 = 4'h1;
   // ****************************************
   // Link sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      QSRC_IDLE = 3'h0,
      QSRC_DLY = 3'h1,
      QSRC_CMD = 3'h3,
      QSRC_DATA = 3'h2,
      QSRC_HOLD = 3'h6
   } qsrc_state_t;
endpackage

// [qsrc_top.sv]
// Quad serial read controller: request side, word buffer and link engine
`timescale 1ns/1ps
module qsrc_top #(
   parameter int WORD_BITS = 128,
   parameter int MAX_WORDS = 4096
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic link_clk,
   input wire logic [7:0] cfg_clk_div,
   input wire logic [1:0] cfg_lines,
   input wire logic [1:0] cfg_pins,
   input wire logic [6:0] cfg_word_len,
   input wire logic [11:0] cfg_word_cnt,
   input wire logic [1:0] cfg_cs_delay,
   input wire logic cfg_evt_frame,
   input wire logic cfg_evt_en,
   input wire logic [qsrc_pkg::QSRC_CMD_W-1:0] cfg_cmd,
   input wire logic rd_req,
   input wire logic [qsrc_pkg::QSRC_ADDR_W-1:0] rd_addr,
   input wire logic rd_take,
   output logic rd_valid,
   output logic [127:0] rd_data,
   output logic busy,
   output logic evt,
   output logic sclk,
   output logic cs_b,
   output logic [3:0] d_out,
   output logic [3:0] d_oe,
   input wire logic [3:0] d_in
);
   import qsrc_pkg::*;

   // ****************************************
   // Parameter check
   // ****************************************
   generate
      if (WORD_BITS != 128 || MAX_WORDS != 4096) begin : g_bad
         $error("qsrc_top supports only 128-bit words and 4096 words");
      end
   endgenerate

   // ****************************************
   // Reset release
   // ****************************************
   logic [1:0] rrs_ff, lrs_ff;
   logic ref_rst_b, link_rst_b;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rrs_ff <= 2'h0;
      end else begin
         rrs_ff <= {rrs_ff[0], 1'b1};
      end
   end

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         lrs_ff <= 2'h0;
      end else begin
         lrs_ff <= {lrs_ff[0], 1'b1};
      end
   end

   assign ref_rst_b = rrs_ff[1];
   assign link_rst_b = lrs_ff[1];

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic busy, stog;
      logic [7:0] cmd;
      logic [23:0] addr;
      logic [1:0] lines, pins;
      logic [6:0] len;
      logic [11:0] cnt;
      logic [1:0] dly;
      logic [7:0] div;
      logic evf, eve;
      logic w_s1, w_s2, w_s3, wseen, pend, ack_tog;
      logic d_s1, d_s2, d_s3, dseen, v0, v1;
      logic [127:0] e0, e1;
      logic evt;
   } qsrc_ref_t;

   typedef struct packed {
      qsrc_state_t st;
      logic [7:0] div_cnt;
      logic sclk, ph, cs_b;
      logic [3:0] dout, doe;
      logic [31:0] sh_out;
      logic [127:0] sh_in;
      logic [7:0] bits;
      logic [11:0] words;
      logic [1:0] dly;
      logic [127:0] wdata;
      logic wtog, done_tog, st_s1, st_s2, st_s3;
      logic st_seen, ak_s1, ak_s2, ak_s3;
      logic [3:0] di_s1, di_s2, di_s3, din;
   } qsrc_link_t;

   localparam qsrc_ref_t REF_RST = '0;
   localparam qsrc_link_t LINK_RST = '{
      st: QSRC_IDLE, div_cnt: QSRC_DIV_RST, cs_b: 1'b1, doe: QSRC_OE_RST,
      default: '0};

   qsrc_ref_t r_ff, nxt_r;
   qsrc_link_t l_ff, nxt_l;
   logic tick, fall;
   logic [7:0] step, nbits, div_eff;
   logic [127:0] shv;
   logic room;

   // ****************************************
   // Request side, word buffer and events
   // ****************************************
   always_comb begin
      nxt_r = r_ff;
      nxt_r.evt = 1'b0;
      nxt_r.w_s1 = l_ff.wtog;
      nxt_r.w_s2 = r_ff.w_s1;
      nxt_r.w_s3 = r_ff.w_s2;
      nxt_r.d_s1 = l_ff.done_tog;
      nxt_r.d_s2 = r_ff.d_s1;
      nxt_r.d_s3 = r_ff.d_s2;
      if (rd_req && !r_ff.busy) begin
         nxt_r.busy = 1'b1;
         nxt_r.stog = !r_ff.stog;
         nxt_r.cmd = cfg_cmd;
         nxt_r.addr = rd_addr;
         nxt_r.lines = cfg_lines;
         nxt_r.pins = cfg_pins;
         nxt_r.len = cfg_word_len;
         nxt_r.cnt = cfg_word_cnt;
         nxt_r.dly = cfg_cs_delay;
         nxt_r.div = cfg_clk_div;
         nxt_r.evf = cfg_evt_frame;
         nxt_r.eve = cfg_evt_en;
      end
      if (r_ff.w_s2 == r_ff.w_s3 && r_ff.w_s3 != r_ff.wseen) begin
         nxt_r.wseen = r_ff.w_s3;
         nxt_r.pend = 1'b1;
      end
      if (r_ff.v0 && rd_take) begin
         nxt_r.e0 = r_ff.e1;
         nxt_r.v0 = r_ff.v1;
         nxt_r.v1 = 1'b0;
      end
      room = !(nxt_r.v0 && nxt_r.v1);
      if (r_ff.pend && room) begin
         if (!nxt_r.v0) begin
            nxt_r.e0 = l_ff.wdata;
            nxt_r.v0 = 1'b1;
         end else begin
            nxt_r.e1 = l_ff.wdata;
            nxt_r.v1 = 1'b1;
         end
         nxt_r.pend = 1'b0;
         nxt_r.ack_tog = !r_ff.ack_tog;
         nxt_r.evt = r_ff.eve && !r_ff.evf;
      end
      if (r_ff.d_s2 == r_ff.d_s3 && r_ff.d_s3 != r_ff.dseen) begin
         nxt_r.dseen = r_ff.d_s3;
         nxt_r.busy = 1'b0;
         nxt_r.evt = r_ff.eve && r_ff.evf;
      end
   end

   always_ff @(posedge ref_clk or negedge ref_rst_b) begin
      if (!ref_rst_b) begin
         r_ff <= REF_RST;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ****************************************
   // Link engine
   // ****************************************
   always_comb begin
      nxt_l = l_ff;
      nxt_l.st_s1 = r_ff.stog;
      nxt_l.st_s2 = l_ff.st_s1;
      nxt_l.st_s3 = l_ff.st_s2;
      nxt_l.ak_s1 = r_ff.ack_tog;
      nxt_l.ak_s2 = l_ff.ak_s1;
      nxt_l.ak_s3 = l_ff.ak_s2;
      nxt_l.di_s1 = d_in;
      nxt_l.di_s2 = l_ff.di_s1;
      nxt_l.di_s3 = l_ff.di_s2;
      if (l_ff.di_s2 == l_ff.di_s3) begin
         nxt_l.din = l_ff.di_s3;
      end
      // Pins pass four flops, so a half period spans at least three clocks
      div_eff = (r_ff.div < QSRC_DIV_MIN) ? QSRC_DIV_MIN : r_ff.div;
      tick = l_ff.div_cnt == div_eff;
      fall = tick && l_ff.sclk;
      nxt_l.div_cnt = tick ? 8'h00 : l_ff.div_cnt + 8'h01;
      case (r_ff.lines)
         QSRC_LINES_2: step = 8'h02;
         QSRC_LINES_4: step = 8'h04;
         default: step = 8'h01;
      endcase
      nbits = l_ff.bits + step;
      case (r_ff.lines)
         QSRC_LINES_2: shv = {l_ff.sh_in[125:0], l_ff.din[1:0]};
         QSRC_LINES_4: shv = {l_ff.sh_in[123:0], l_ff.din};
         default: begin
            if (r_ff.pins == QSRC_PINS_3) begin
               shv = {l_ff.sh_in[126:0], l_ff.din[0]};
            end else begin
               shv = {l_ff.sh_in[126:0], l_ff.din[1]};
            end
         end
      endcase
      case (l_ff.st)
         QSRC_IDLE: begin
            nxt_l.div_cnt = QSRC_DIV_RST;
            nxt_l.sclk = 1'b0;
            if (l_ff.st_s2 == l_ff.st_s3 && l_ff.st_s3 != l_ff.st_seen) begin
               nxt_l.st_seen = l_ff.st_s3;
               nxt_l.cs_b = 1'b0;
               nxt_l.sh_out = {r_ff.cmd, r_ff.addr};
               nxt_l.dout = {3'h0, r_ff.cmd[QSRC_CMD_W-1]};
               nxt_l.doe = QSRC_OE_D0;
               nxt_l.words = r_ff.cnt;
               nxt_l.bits = 8'h00;
               nxt_l.dly = r_ff.dly;
               nxt_l.ph = 1'b0;
               nxt_l.st = (r_ff.dly == 2'h0) ? QSRC_CMD : QSRC_DLY;
            end
         end
         QSRC_DLY: begin
            if (tick) begin
               nxt_l.ph = !l_ff.ph;
               if (l_ff.ph) begin
                  nxt_l.dly = l_ff.dly - 2'h1;
                  if (l_ff.dly == 2'h1) begin
                     nxt_l.st = QSRC_CMD;
                  end
               end
            end
         end
         QSRC_CMD: begin
            if (tick) begin
               nxt_l.sclk = !l_ff.sclk;
            end
            if (fall) begin
               nxt_l.sh_out = {l_ff.sh_out[QSRC_HDR_W-2:0], 1'b0};
               nxt_l.dout = {3'h0, l_ff.sh_out[QSRC_HDR_W-2]};
               nxt_l.bits = l_ff.bits + 8'h01;
               if (l_ff.bits == QSRC_HDR_LAST) begin
                  nxt_l.st = QSRC_DATA;
                  nxt_l.bits = 8'h00;
                  nxt_l.sh_in = '0;
                  nxt_l.dout = 4'h0;
                  nxt_l.doe = (r_ff.pins == QSRC_PINS_4) ?
                     QSRC_OE_D0 : QSRC_OE_RST;
               end
            end
         end
         QSRC_DATA: begin
            if (tick) begin
               nxt_l.sclk = !l_ff.sclk;
            end
            if (fall) begin
               nxt_l.sh_in = shv;
               nxt_l.bits = nbits;
               if (nbits > {1'b0, r_ff.len}) begin
                  nxt_l.wdata = shv;
                  nxt_l.wtog = !l_ff.wtog;
                  nxt_l.bits = 8'h00;
                  nxt_l.sh_in = '0;
                  nxt_l.st = QSRC_HOLD;
               end
            end
         end
         QSRC_HOLD: begin
            nxt_l.div_cnt = QSRC_DIV_RST;
            if (l_ff.ak_s2 == l_ff.ak_s3 && l_ff.ak_s3 == l_ff.wtog) begin
               if (l_ff.words == 12'h000) begin
                  nxt_l.cs_b = 1'b1;
                  nxt_l.doe = QSRC_OE_RST;
                  nxt_l.done_tog = !l_ff.done_tog;
                  nxt_l.st = QSRC_IDLE;
               end else begin
                  nxt_l.words = l_ff.words - 12'h001;
                  nxt_l.st = QSRC_DATA;
               end
            end
         end
         default: begin
            nxt_l.st = QSRC_IDLE;
            nxt_l.cs_b = 1'b1;
            nxt_l.sclk = 1'b0;
         end
      endcase
   end

   always_ff @(posedge link_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         l_ff <= LINK_RST;
      end else begin
         l_ff <= nxt_l;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rd_valid = r_ff.v0;
   assign rd_data = r_ff.e0;
   assign busy = r_ff.busy;
   assign evt = r_ff.evt;
   assign sclk = l_ff.sclk;
   assign cs_b = l_ff.cs_b;
   assign d_out = l_ff.dout;
   assign d_oe = l_ff.doe;
endmodule

// [qsrc_props.sv]
// Port checks of the quad serial read controller
`timescale 1ns/1ps
module qsrc_props (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic link_clk,
   input wire logic rd_req,
   input wire logic rd_take,
   input wire logic rd_valid,
   input wire logic [127:0] rd_data,
   input wire logic busy,
   input wire logic evt,
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic [3:0] d_out,
   input wire logic [3:0] d_oe
);
   // ****************************************
   // Link and request checks
   // ****************************************
   sequence s_taken;
      rd_req && !busy;
   endsequence
   sequence s_held;
      rd_valid && !rd_take;
   endsequence
   sclk_idle_a: assert property (
      @(posedge link_clk) disable iff (!rst_b) cs_b |-> !sclk
   ) else $error("sclk moves outside a frame");
   oe_idle_a: assert property (
      @(posedge link_clk) disable iff (!rst_b) cs_b |-> d_oe == 4'h0
   ) else $error("line driven while deselected");
   d0_fall_a: assert property (
      @(posedge link_clk) disable iff (!rst_b)
      !cs_b && $past(!cs_b) && d_oe[0] && $past(d_oe[0])
      && $changed(d_out[0]) |-> $fell(sclk)
   ) else $error("d0 changed away from sclk fall");
   cs_start_a: assert property (
      @(posedge link_clk) disable iff (!rst_b)
      $fell(cs_b) |-> !sclk && d_oe[0]
   ) else $error("bad frame start");
   cs_end_a: assert property (
      @(posedge link_clk) disable iff (!rst_b) $rose(cs_b) |-> !sclk
   ) else $error("select dropped with sclk high");
   req_busy_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b) s_taken |=> busy
   ) else $error("request not taken");
   evt_pulse_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b) evt |=> !evt
   ) else $error("event longer than one cycle");
   sel_busy_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b) !cs_b |-> busy
   ) else $error("select active while idle");
   busy_end_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b) $fell(busy) |-> cs_b
   ) else $error("frame ended with select active");
   word_hold_a: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      s_held |=> rd_valid && $stable(rd_data)
   ) else $error("unread word lost");
endmodule
bind qsrc_top qsrc_props u_props (.ref_clk, .rst_b, .link_clk, .rd_req,
   .rd_take, .rd_valid, .rd_data, .busy, .evt, .sclk, .cs_b, .d_out, .d_oe);

// [qsrc_flash.sv]
// Serial flash model at the far side of the link
`timescale 1ns/1ps
module qsrc_flash (
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic [3:0] d_pin,
   output logic [3:0] d_drv,
   output logic [31:0] hdr
);
   int bit_cnt = 0;
   int fall_cnt = 0;
   initial d_drv = 4'h5;
   always @(negedge cs_b) begin
      bit_cnt = 0;
      fall_cnt = 0;
   end
   // Header taken on rising edges in mode zero
   always @(posedge sclk) begin
      if (!cs_b && bit_cnt < 32) begin
         hdr = {hdr[30:0], d_pin[0]};
         bit_cnt++;
      end
   end
   // Data launched on falling edges after the header
   always @(negedge sclk) begin
      if (!cs_b && bit_cnt == 32) begin
         d_drv = 4'(fall_cnt) ^ 4'ha;
         fall_cnt++;
      end
   end
   // Released lines show no stale value
   always @(posedge cs_b) d_drv = ~d_drv;
endmodule

// [qsrc_tb.sv]
// Self-checking bench of the quad serial read controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   samples_checked++; \
   if ((got) !== (ex)) begin \
      fail_count++; \
      $display("MISMATCH %s exp %h got %h", nm, ex, got); \
   end \
end
module testbench;
   import qsrc_pkg::*;
   logic ref_clk = 0, link_clk = 0, rst_b, rd_req, rd_take, rd_valid, busy;
   logic evt, sclk, cs_b, cfg_evt_frame, cfg_evt_en;
   logic [7:0] cfg_clk_div, cfg_cmd;
   logic [1:0] cfg_lines, cfg_pins, cfg_cs_delay;
   logic [6:0] cfg_word_len;
   logic [11:0] cfg_word_cnt;
   logic [23:0] rd_addr;
   logic [127:0] rd_data;
   logic [3:0] d_out, d_oe, d_in, f_drv;
   logic [31:0] f_hdr;
   int fail_count = 0, samples_checked = 0, evt_seen = 0;
   realtime cs_fall_t = -1.0, lead_t = 0.0;
   always #12.5 ref_clk = ~ref_clk;
   always #6 link_clk = ~link_clk;
   assign d_in = (d_oe & d_out) | (~d_oe & f_drv);
   always @(posedge ref_clk) if (evt === 1'b1) evt_seen++;
   always @(negedge cs_b) cs_fall_t = $realtime;
   always @(posedge sclk) begin
      if (cs_fall_t >= 0.0) begin
         lead_t = $realtime - cs_fall_t;
         cs_fall_t = -1.0;
      end
   end
   qsrc_top u_dut (.ref_clk, .rst_b, .link_clk, .cfg_clk_div, .cfg_lines,
      .cfg_pins, .cfg_word_len, .cfg_word_cnt, .cfg_cs_delay, .cfg_evt_frame,
      .cfg_evt_en, .cfg_cmd, .rd_req, .rd_addr, .rd_take, .rd_valid, .rd_data,
      .busy, .evt, .sclk, .cs_b, .d_out, .d_oe, .d_in);
   qsrc_flash u_flash (.sclk, .cs_b, .d_pin(d_in), .d_drv(f_drv),
      .hdr(f_hdr));
   // ****************************************
   // Shared helpers
   // ****************************************
   function automatic logic [3:0] chunk(int k, logic [1:0] ln, pn);
      logic [3:0] v;
      v = 4'(k) ^ 4'ha;
      if (ln == QSRC_LINES_4) return v;
      if (ln == QSRC_LINES_2) return {2'h0, v[1:0]};
      return (pn == QSRC_PINS_3) ? {3'h0, v[0]} : {3'h0, v[1]};
   endfunction
   task automatic print_verdict();
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic run_frame(logic [1:0] ln, pn, logic [6:0] len,
      logic [11:0] cnt, logic [1:0] dly, logic ef, en, int stall, hold);
      int bpf, fpw, t, hd;
      logic [127:0] ex, mask;
      @(negedge ref_clk);
      cfg_lines = ln;
      cfg_pins = pn;
      cfg_word_len = len;
      cfg_word_cnt = cnt;
      cfg_cs_delay = dly;
      cfg_evt_frame = ef;
      cfg_evt_en = en;
      cfg_cmd = cfg_cmd + 8'h11;
      rd_addr = rd_addr + 24'h010203;
      evt_seen = 0;
      rd_req = 1;
      repeat (hold) @(negedge ref_clk);
      rd_req = 0;
      bpf = (ln == QSRC_LINES_4) ? 4 : (ln == QSRC_LINES_2) ? 2 : 1;
      fpw = (len + bpf) / bpf;
      mask = (128'h1 << (len + 1)) - 128'h1;
      hd = (cfg_clk_div < QSRC_DIV_MIN) ? QSRC_DIV_MIN : cfg_clk_div;
      repeat (stall) @(negedge ref_clk);
      if (stall > 0) `CHK("cs stalled", 1'b0, cs_b)
      rd_take = 1;
      for (int w = 0; w <= cnt; w++) begin
         t = 0;
         while (rd_valid !== 1'b1 && t < 20000) begin
            @(negedge ref_clk);
            t++;
         end
         `CHK("rd_valid", 1'b1, rd_valid)
         ex = 0;
         for (int n = w * fpw; n < (w + 1) * fpw; n++) begin
            ex = (ex << bpf) | chunk(n, ln, pn);
         end
         `CHK("rd_data", ex & mask, rd_data & mask)
         @(negedge ref_clk);
      end
      t = 0;
      while (busy !== 1'b0 && t < 20000) begin
         @(negedge ref_clk);
         t++;
      end
      repeat (4) @(negedge ref_clk);
      `CHK("cs_b", 1'b1, cs_b)
      `CHK("sclk", 1'b0, sclk)
      `CHK("extra", 1'b0, rd_valid | busy)
      `CHK("header", {cfg_cmd, rd_addr}, f_hdr)
      `CHK("evt", en ? (ef ? 1 : cnt + 1) : 0, evt_seen)
      `CHK("cs lead", (2 * dly + 1) * (hd + 1), int'(lead_t / 12.0))
      rd_take = 0;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic sc_reset();
      `CHK("rst out", 5'h08, {sclk, cs_b, busy, rd_valid, evt})
      `CHK("rst oe", 4'h0, d_oe)
      rst_b = 1;
      repeat (3) @(negedge ref_clk);
   endtask
   task automatic sc_single();
      run_frame(QSRC_LINES_1, QSRC_PINS_3, 7'h00, 12'h001, 2'h0, 0, 1, 0, 1);
      run_frame(QSRC_LINES_1, QSRC_PINS_4, 7'h07, 12'h003, 2'h3, 0, 1, 0, 1);
   endtask
   task automatic sc_dual_refused();
      run_frame(QSRC_LINES_2, QSRC_PINS_6, 7'h0c, 12'h002, 2'h1, 0, 0, 0, 4);
   endtask
   task automatic sc_quad_long();
      cfg_clk_div = 8'h02;
      run_frame(QSRC_LINES_4, QSRC_PINS_6, 7'h7f, 12'h001, 2'h2, 1, 1, 0, 1);
      cfg_clk_div = 8'h01;
   endtask
   task automatic sc_quad_stall();
      run_frame(QSRC_LINES_4, QSRC_PINS_6, 7'h07, 12'h004, 2'h0, 1, 1, 400, 1);
   endtask
   initial begin
      {rst_b, rd_req, rd_take, cfg_evt_frame, cfg_evt_en} = 5'h00;
      {cfg_lines, cfg_pins, cfg_cs_delay} = 6'h00;
      {cfg_word_len, cfg_word_cnt} = 19'h00000;
      {cfg_clk_div, cfg_cmd, rd_addr} = {8'h01, 8'h3b, 24'h001000};
      repeat (16) @(negedge ref_clk);
      sc_reset();
      sc_single();
      sc_dual_refused();
      sc_quad_long();
      sc_quad_stall();
      print_verdict();
   end
   initial begin
      #2000000;
      fail_count++;
      print_verdict();
   end
endmodule
